// ===== design/misr_cfg.svh
`ifndef MISR_CFG_SVH
`define MISR_CFG_SVH
`define MISR_ADDR_STATUS 8'h38
`define MISR_ADDR_MASK 8'h3C
`define MISR_ADDR_LPI_CS 8'h30
`define MISR_ADDR_TS_STAT 8'h40
`define MISR_ADDR_WAKE_CS 8'h44
`define MISR_ADDR_CFG 8'h48
`define MISR_BIT_LPI 10
`define MISR_BIT_TS 9
`define MISR_BIT_CSUM 7
`define MISR_BIT_TX 6
`define MISR_BIT_RX 5
`define MISR_BIT_SUM 4
`define MISR_BIT_WAKE 3
`define MISR_BIT_RGL 0
`define MISR_MASK_WMASK 32'h0000_0609
`define MISR_RESP_OKAY 2'h0
`define MISR_RESP_SLVERR 2'h2
`endif

// ===== design/misr_pkg.sv
package misr_pkg;
  typedef enum logic [1:0] {
    MISR_IDLE = 2'h0,
    MISR_RESP = 2'h1
  } misr_bus_e;
  typedef logic [31:0] misr_word_t;
endpackage

// ===== design/misr_sticky.sv
`include "misr_cfg.svh"
module misr_sticky
  import misr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Event and clear
  input wire logic set_evt,
  input wire logic clr_req,
  // Flag
  output logic flag
);
  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_req) begin
      flag <= 1'b0;
    end
  end
endmodule

// ===== design/misr_top.sv
// Operation
// RULE1: Any transmit or receive low-power idle entry or exit sets the idle event flag.
// RULE2: Idle event flag clears only on reading byte 0 of idle control/status.
// RULE3: Timestamp flag sets when system time reaches or passes the target time.
// RULE4: Timestamp flag also sets on seconds counter overflow.
// RULE5: Timestamp flag clears only on reading byte 0 of timestamp status.
// RULE6: Checksum counter flag follows OR of receive checksum statistics interrupt bits.
// RULE7: Transmit counter flag follows OR of transmit statistics interrupt bits.
// RULE8: Receive counter flag follows OR of receive statistics interrupt bits.
// RULE9: Counter summary flag is OR of the three counter flags.
// RULE10: Wake flag sets on magic packet or wake frame while powered down.
// RULE11: Wake flag clears once both wake-detect bits are cleared by a read.
// RULE12: Mask register lets software keep events off the interrupt line.
// RULE13: Idle mask bit one blocks interrupt from the idle event flag.
// RULE14: Timestamp mask bit one blocks interrupt from the timestamp flag.
// RULE15: Wake mask bit one blocks interrupt from the wake flag.
// RULE16: Reduced gigabit flag and mask are reserved when MII or RMII is selected.
// RULE17: Four separate idle entry/exit bits, each cleared by reading idle control/status.
// RULE18: Interrupt asserts while any unmasked flag is set; counter flags unmasked here.
`include "misr_cfg.svh"
module misr_top
  import misr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Low-power idle event pulses: tx entry, tx exit, rx entry, rx exit
  input wire logic [3:0] lpi_evt,
  // Timestamp unit pulses
  input wire logic ts_target_hit,
  input wire logic ts_sec_ovf,
  // Statistics interrupt registers, any bit set
  input wire logic rx_csum_irq_any,
  input wire logic tx_stat_irq_any,
  input wire logic rx_stat_irq_any,
  // Power management unit
  input wire logic wake_magic,
  input wire logic wake_frame,
  input wire logic power_down,
  // Reduced gigabit link change pulse
  input wire logic rgl_evt,
  // Interrupt
  output logic mac_irq_out
);
  misr_bus_e wr_st_ff;
  misr_bus_e rd_st_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [3:0] lpi_bits_ff;
  logic [1:0] wake_bits_ff;
  logic ts_stat_ff;
  logic csum_ff;
  logic tx_ff;
  logic rx_ff;
  logic sum_ff;
  logic lpi_event_mask_ff;
  logic timestamp_event_mask_ff;
  logic wake_event_mask_ff;
  logic reduced_gig_link_mask_ff;
  logic rgmii_sel_ff;
  logic lpi_event_flag;
  logic timestamp_event_flag;
  logic reduced_gig_link_flag;
  logic rd_take;
  logic wr_do;
  logic aw_hs;
  logic w_hs;
  logic rd_lpi_b0;
  logic rd_ts_b0;
  logic rd_wake;
  logic nxt_irq;
  misr_word_t rd_word;
  misr_word_t status_word;
  misr_word_t mask_word;

  // A channel moves only when its valid and ready are both high
  assign rd_take = (rd_st_ff == MISR_IDLE) && s_axi_arvalid && s_axi_arready;
  // Any read is a full word, so byte 0 is always included
  assign rd_lpi_b0 = rd_take && (s_axi_araddr == `MISR_ADDR_LPI_CS); // RULE2
  assign rd_ts_b0 = rd_take && (s_axi_araddr == `MISR_ADDR_TS_STAT); // RULE5
  assign rd_wake = rd_take && (s_axi_araddr == `MISR_ADDR_WAKE_CS);
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign wr_do = (wr_st_ff == MISR_IDLE) && (aw_got_ff || aw_hs) && (w_got_ff || w_hs);

  // Write channel: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_ff <= MISR_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MISR_RESP_OKAY;
    end else begin
      case (wr_st_ff)
        MISR_IDLE: begin
          if (aw_hs) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
          end
          if (w_hs) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
          end
          if (wr_do) begin
            wr_st_ff <= MISR_RESP;
            s_axi_bvalid <= 1'b1;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            case (aw_got_ff ? awaddr_ff : s_axi_awaddr)
              `MISR_ADDR_MASK, `MISR_ADDR_CFG: s_axi_bresp <= `MISR_RESP_OKAY;
              default: s_axi_bresp <= `MISR_RESP_SLVERR;
            endcase
          end
        end
        MISR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_st_ff <= MISR_IDLE;
          end
        end
        default: wr_st_ff <= MISR_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      // Ready drops once a half is held, so nothing is taken twice
      s_axi_awready <= (wr_st_ff == MISR_IDLE) && !wr_do && !aw_got_ff && !aw_hs;
      s_axi_wready <= (wr_st_ff == MISR_IDLE) && !wr_do && !w_got_ff && !w_hs;
    end
  end

  // Mask and interface-select registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpi_event_mask_ff <= 1'b0;
      timestamp_event_mask_ff <= 1'b0;
      wake_event_mask_ff <= 1'b0;
      reduced_gig_link_mask_ff <= 1'b0;
      rgmii_sel_ff <= 1'b0;
    end else if (wr_do) begin
      if ((aw_got_ff ? awaddr_ff : s_axi_awaddr) == `MISR_ADDR_MASK) begin // RULE12
        if ((w_got_ff ? wstrb_ff[1] : s_axi_wstrb[1])) begin
          lpi_event_mask_ff <= w_got_ff ? wdata_ff[`MISR_BIT_LPI] : s_axi_wdata[`MISR_BIT_LPI];
          timestamp_event_mask_ff <= w_got_ff ? wdata_ff[`MISR_BIT_TS] : s_axi_wdata[`MISR_BIT_TS];
        end
        if ((w_got_ff ? wstrb_ff[0] : s_axi_wstrb[0])) begin
          wake_event_mask_ff <= w_got_ff ? wdata_ff[`MISR_BIT_WAKE] : s_axi_wdata[`MISR_BIT_WAKE];
          reduced_gig_link_mask_ff <= w_got_ff ? wdata_ff[`MISR_BIT_RGL] :
                                      s_axi_wdata[`MISR_BIT_RGL];
        end
      end
      if ((aw_got_ff ? awaddr_ff : s_axi_awaddr) == `MISR_ADDR_CFG &&
          (w_got_ff ? wstrb_ff[0] : s_axi_wstrb[0])) begin
        rgmii_sel_ff <= w_got_ff ? wdata_ff[0] : s_axi_wdata[0];
      end
    end
  end

  // Four idle entry/exit bits, each sticky with set over clear
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lpi
      misr_sticky u_lpi (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_evt(lpi_evt[gi]), // RULE17
        .clr_req(rd_lpi_b0),
        .flag(lpi_bits_ff[gi])
      );
    end
  endgenerate

  misr_sticky u_lpi_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(|lpi_evt), // RULE1
    .clr_req(rd_lpi_b0),
    .flag(lpi_event_flag)
  );

  misr_sticky u_ts_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(ts_target_hit || ts_sec_ovf), // RULE3 RULE4
    .clr_req(rd_ts_b0),
    .flag(timestamp_event_flag)
  );

  misr_sticky u_rgl_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(rgl_evt && rgmii_sel_ff), // RULE16
    .clr_req(!rgmii_sel_ff),
    .flag(reduced_gig_link_flag)
  );

  // Timestamp status bit 0 mirrors the flag source for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ts_stat_ff <= 1'b0;
    end else if (ts_target_hit || ts_sec_ovf) begin
      ts_stat_ff <= 1'b1;
    end else if (rd_ts_b0) begin
      ts_stat_ff <= 1'b0;
    end
  end

  // Wake-detect bits: magic at 5, wake frame at 6
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_bits_ff <= 2'h0;
    end else begin
      wake_bits_ff[0] <= (wake_magic && power_down) || (wake_bits_ff[0] && !rd_wake); // RULE10
      wake_bits_ff[1] <= (wake_frame && power_down) || (wake_bits_ff[1] && !rd_wake);
    end
  end

  // Counter flags are level mirrors of their sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csum_ff <= 1'b0;
      tx_ff <= 1'b0;
      rx_ff <= 1'b0;
      sum_ff <= 1'b0;
    end else begin
      csum_ff <= rx_csum_irq_any; // RULE6
      tx_ff <= tx_stat_irq_any; // RULE7
      rx_ff <= rx_stat_irq_any; // RULE8
      sum_ff <= rx_csum_irq_any || tx_stat_irq_any || rx_stat_irq_any; // RULE9
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`MISR_BIT_LPI] = lpi_event_flag;
    status_word[`MISR_BIT_TS] = timestamp_event_flag;
    status_word[`MISR_BIT_CSUM] = csum_ff;
    status_word[`MISR_BIT_TX] = tx_ff;
    status_word[`MISR_BIT_RX] = rx_ff;
    status_word[`MISR_BIT_SUM] = sum_ff;
    status_word[`MISR_BIT_WAKE] = |wake_bits_ff; // RULE11
    status_word[`MISR_BIT_RGL] = reduced_gig_link_flag && rgmii_sel_ff; // RULE16
    mask_word = 32'h0000_0000;
    mask_word[`MISR_BIT_LPI] = lpi_event_mask_ff;
    mask_word[`MISR_BIT_TS] = timestamp_event_mask_ff;
    mask_word[`MISR_BIT_WAKE] = wake_event_mask_ff;
    mask_word[`MISR_BIT_RGL] = reduced_gig_link_mask_ff && rgmii_sel_ff;
    case (s_axi_araddr)
      `MISR_ADDR_STATUS: rd_word = status_word;
      `MISR_ADDR_MASK: rd_word = mask_word;
      `MISR_ADDR_LPI_CS: rd_word = {28'h0000000, lpi_bits_ff};
      `MISR_ADDR_TS_STAT: rd_word = {31'h0, ts_stat_ff};
      `MISR_ADDR_WAKE_CS: rd_word = {25'h0, wake_bits_ff, 5'h00};
      `MISR_ADDR_CFG: rd_word = {31'h0, rgmii_sel_ff};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel; the slave answers one cycle after taking the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_ff <= MISR_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MISR_RESP_OKAY;
    end else begin
      s_axi_arready <= (rd_st_ff == MISR_IDLE) && !rd_take;
      case (rd_st_ff)
        MISR_IDLE: begin
          if (rd_take) begin
            rd_st_ff <= MISR_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            case (s_axi_araddr)
              `MISR_ADDR_STATUS, `MISR_ADDR_MASK, `MISR_ADDR_LPI_CS, `MISR_ADDR_TS_STAT,
              `MISR_ADDR_WAKE_CS, `MISR_ADDR_CFG: s_axi_rresp <= `MISR_RESP_OKAY;
              default: s_axi_rresp <= `MISR_RESP_SLVERR;
            endcase
          end
        end
        MISR_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_st_ff <= MISR_IDLE;
          end
        end
        default: rd_st_ff <= MISR_IDLE;
      endcase
    end
  end

  // Counter flags have their own masks at the statistics unit
  assign nxt_irq = (lpi_event_flag && !lpi_event_mask_ff) // RULE13
                || (timestamp_event_flag && !timestamp_event_mask_ff) // RULE14
                || ((|wake_bits_ff) && !wake_event_mask_ff) // RULE15
                || (reduced_gig_link_flag && rgmii_sel_ff && !reduced_gig_link_mask_ff)
                || sum_ff; // RULE18

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mac_irq_out <= 1'b0;
    end else begin
      mac_irq_out <= nxt_irq;
    end
  end

  property p_lpi_set;
    @(posedge aclk) disable iff (!aresetn) (|lpi_evt) |=> lpi_event_flag;
  endproperty
  a_lpi_set: assert property (p_lpi_set) else $error("idle flag not set"); // RULE1

  property p_lpi_hold;
    @(posedge aclk) disable iff (!aresetn)
      (lpi_event_flag && !rd_lpi_b0) |=> lpi_event_flag;
  endproperty
  a_lpi_hold: assert property (p_lpi_hold) else $error("idle flag lost"); // RULE2

  property p_ts_set;
    @(posedge aclk) disable iff (!aresetn)
      (ts_target_hit || ts_sec_ovf) |=> timestamp_event_flag;
  endproperty
  a_ts_set: assert property (p_ts_set) else $error("ts flag not set"); // RULE3

  property p_ts_clr;
    @(posedge aclk) disable iff (!aresetn)
      (rd_ts_b0 && !ts_target_hit && !ts_sec_ovf) |=> !timestamp_event_flag;
  endproperty
  a_ts_clr: assert property (p_ts_clr) else $error("ts flag not cleared"); // RULE5

  property p_csum;
    @(posedge aclk) disable iff (!aresetn) 1'b1 |=> (csum_ff == $past(rx_csum_irq_any));
  endproperty
  a_csum: assert property (p_csum) else $error("csum flag wrong"); // RULE6

  property p_sum;
    @(posedge aclk) disable iff (!aresetn) sum_ff == (csum_ff || tx_ff || rx_ff);
  endproperty
  a_sum: assert property (p_sum) else $error("summary flag wrong"); // RULE9

  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
      (wake_magic && power_down) |=> status_word[`MISR_BIT_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag not set"); // RULE10

  property p_lpi_mask;
    @(posedge aclk) disable iff (!aresetn)
      (lpi_event_mask_ff && !timestamp_event_flag && (wake_bits_ff == 2'h0) && !sum_ff
       && !reduced_gig_link_flag) |=> !mac_irq_out;
  endproperty
  a_lpi_mask: assert property (p_lpi_mask) else $error("masked irq seen"); // RULE13

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      (timestamp_event_flag && !timestamp_event_mask_ff) |=> mac_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // RULE18
endmodule

// ===== tb/misr_host.sv
module misr_host (
  // Clock
  input wire logic aclk,
  // Write address and data
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  // Write response
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Payload inverted once taken, so a late sample cannot match by luck
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && s_axi_awready) begin
        aw_open = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w_open && s_axi_wready) begin
        w_open = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    // Response ready is left high, so a following call never re-raises it in the same step
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
  endtask
endmodule

// ===== tb/test_mac_interrupt_status_mask.sv
`include "misr_cfg.svh"
module test_mac_interrupt_status_mask
  import misr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ST = `MISR_ADDR_STATUS;
  localparam logic [7:0] MK = `MISR_ADDR_MASK;
  localparam logic [7:0] CF = `MISR_ADDR_CFG;
  localparam logic [1:0] ERR = `MISR_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, lpi_evt;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mac_irq_out;
  logic ts_target_hit, ts_sec_ovf, rx_csum_irq_any, tx_stat_irq_any, rx_stat_irq_any;
  logic wake_magic, wake_frame, rgl_evt;
  logic power_down = 1'b0;
  logic [8:0] ev = 9'h000;
  logic [2:0] stat_any = 3'h0;
  logic [33:0] q_rd[$];
  logic [1:0] q_wr[$];
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  misr_word_t rnd;
  assign {rgl_evt, wake_frame, wake_magic, ts_sec_ovf, ts_target_hit, lpi_evt} = ev;
  assign {rx_csum_irq_any, tx_stat_irq_any, rx_stat_irq_any} = stat_any;
  always #20 aclk = ~aclk;
  misr_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .lpi_evt, .ts_target_hit, .ts_sec_ovf, .rx_csum_irq_any,
    .tx_stat_irq_any, .rx_stat_irq_any, .wake_magic, .wake_frame, .power_down,
    .rgl_evt, .mac_irq_out);
  misr_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
  task automatic note(input string what, input logic [33:0] e, input logic [33:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] s);
    note("read resp and data", e, s);
  endtask
  task automatic cmp_wr(input logic [1:0] e, input logic [1:0] s);
    note("write resp", {32'h0, e}, {32'h0, s});
  endtask
  task automatic cmp_irq(input logic e, input logic s);
    note("mac_irq_out", {33'h0, e}, {33'h0, s});
  endtask
  task print_verdict;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input misr_word_t d, input logic [1:0] r = 2'h0);
    q_rd.push_back({r, d});
    host.rd(a);
  endtask
  task automatic wr(input logic [7:0] a, input misr_word_t d, input logic [3:0] s,
    input logic [1:0] r = 2'h0);
    q_wr.push_back(r);
    host.wr(a, d, s);
  endtask
  task automatic pulse(input int k, input logic pd);
    @(posedge aclk);
    power_down <= pd;
    ev <= 9'h001 << k;
    @(posedge aclk);
    ev <= 9'h000;
  endtask
  // Four edges cover flag lag plus summary and irq registers
  task automatic chk_irq(input logic e);
    repeat (4) @(posedge aclk);
    cmp_irq(e, mac_irq_out);
  endtask
  function automatic misr_word_t sbit(int k);
    return k < 4 ? 32'h0000_0400 : k < 6 ? 32'h0000_0200 : 32'h0000_0008;
  endfunction
  function automatic logic [7:0] caddr(int k);
    return k < 4 ? `MISR_ADDR_LPI_CS : k < 6 ? `MISR_ADDR_TS_STAT : `MISR_ADDR_WAKE_CS;
  endfunction
  function automatic misr_word_t cval(int k);
    return k < 4 ? 32'h0000_0001 << k : k < 6 ? 32'h0000_0001 : k == 6 ? 32'h20 : 32'h40;
  endfunction
  always @(posedge aclk) begin
    cycles++;
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      cmp_rd(q_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      cmp_wr(q_wr.pop_front(), s_axi_bresp);
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    rnd = $urandom(18571);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ST, 32'h0);
    rd(MK, 32'h0);
    chk_irq(1'b0);
    rd(8'h50, 32'h0, ERR);
    wr(ST, rnd, 4'hF, ERR);
    wr(MK, $urandom | 32'h0000_0609, 4'hF);
    rd(MK, 32'h0000_0608);
    pulse(8, 1'b0);
    rd(ST, 32'h0);
    wr(CF, 32'h0000_0001, 4'hF);
    rd(CF, 32'h0000_0001);
    wr(MK, 32'h0, 4'hF);
    wr(MK, $urandom | 32'h0000_0609, 4'h1);
    rd(MK, 32'h0000_0009);
    wr(MK, $urandom | 32'h0000_0609, 4'h2);
    rd(MK, 32'h0000_0609);
    pulse(8, 1'b0);
    chk_irq(1'b0);
    rd(ST, 32'h0000_0001);
    wr(MK, 32'h0, 4'hF);
    chk_irq(1'b1);
    wr(CF, 32'h0, 4'hF);
    rd(ST, 32'h0);
    chk_irq(1'b0);
    pulse(6, 1'b0);
    pulse(7, 1'b0);
    rd(ST, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wr(MK, sbit(k), 4'hF);
      pulse(k, 1'b1);
      chk_irq(1'b0);
      rd(ST, sbit(k));
      rd(ST, sbit(k));
      wr(MK, 32'h0, 4'hF);
      chk_irq(1'b1);
      rd(caddr(k), cval(k));
      rd(ST, 32'h0);
      chk_irq(1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      automatic logic [2:0] v = 3'(i) ^ rnd[2:0];
      @(posedge aclk);
      stat_any <= v;
      chk_irq(|v);
      rd(ST, {24'h0, v, |v, 4'h0});
    end
    print_verdict();
  end
endmodule
